// ==== hw/msseq_pkg.sv ====
package msseq_pkg;
  // clock and oscillator timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int DISCHARGE_NS = 150;
  localparam int DISCHARGE_CYC =
    (DISCHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DUTY_NUM = 4;
  localparam int DUTY_DEN = 5;
  // sequencing counts, in oscillator cycles
  localparam int AUX_SS_CYCLES = 4096;
  localparam int BUCK_SS_CYCLES = 2048;
  localparam int BOOST_START_CYCLES = 4096;
  localparam int FAULT_CYCLES = 100000;
  // channel indices
  localparam int NCH = 4;
  localparam int NFT = 5;
  localparam int CH_BUCK = 0;
  localparam int CH_AUX1 = 1;
  localparam int CH_AUX2 = 2;
  localparam int CH_AUX3 = 3;
  localparam int FT_BOOST = 4;
  // widths
  localparam int SS_W = 13;
  localparam int FT_W = 17;
  localparam int PER_W = 16;
  localparam int REF_W = 13;
  localparam logic [REF_W-1:0] REF_FULL = 13'h1000;
  // register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_REF_LO = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_REF_HI = 8'h0C;
  localparam int CTRL_INVERT = 0;
  localparam int ST_FAULT = 0;
  localparam int ST_UV = 1;
  localparam int ST_BOOST_UP = 2;
  localparam int ST_THERMAL = 3;
  localparam int ST_ON = 4;
  localparam int ST_DONE = 8;
  localparam int REF_HI_SHIFT = 16;

  typedef enum logic [1:0] {
    OSC_CHARGE = 2'b01,
    OSC_DISCHARGE = 2'b10
  } msseq_osc_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } msseq_apb_type;

  typedef struct packed {
    logic boostRegOk;
    logic boostAboveUv;
    logic [NFT-1:0] outOfReg;
    logic timingTrip;
    logic [2:0] pulseEnd;
    logic thermalLimit;
  } msseq_sense_type;

  typedef struct packed {
    msseq_osc_type osc;
    logic [PER_W-1:0] oscCnt;
    logic [PER_W-1:0] period;
    logic boostUp;
    logic [SS_W-1:0] startCnt;
    logic fault;
    logic [NCH-1:0][SS_W-1:0] ssCnt;
    logic [NFT-1:0][FT_W-1:0] ftCnt;
    logic [2:0] gateOn;
    logic [2:0] gateLvl;
    logic [NCH-1:0] chanOn;
    logic [NCH-1:0][REF_W-1:0] refCode;
    logic startOsc;
    logic pwmEn;
    logic refEn;
    logic discharge;
    logic goodBuck;
    logic goodAux1;
    logic flagLow;
    logic invert;
    logic [31:0] prdata;
  } msseq_state_type;
endpackage : msseq_pkg

// ==== hw/msseq_sequencer.sv ====
// What this block does
// RULE1: boost channel starts on its enable alone, needing no other channel.
// RULE2: buck and aux channels start on their enables only after boost regulates.
// RULE3: enabled aux channels ramp their reference from zero over 4096 cycles.
// RULE4: boost channel has no soft-start ramp.
// RULE5: buck ramp lasts 2048 cycles, half the others.
// RULE6: any channel out of regulation 100,000 cycles latches all channels and the boost switch off; reference and oscillator keep running.
// RULE7: fault latch holds until boost enable toggles or power cycles.
// RULE8: fault detection off while a channel's first soft-start runs.
// RULE9: boost rail under 2.5V shuts all channels at once.
// RULE10: after undervoltage shutdown boost retries start-up by itself.
// RULE11: boost not regulated by end of start interval retriggers fault.
// RULE12: buck good pulls low after buck soft-start; released otherwise.
// RULE13: aux1 good pulls low after aux1 soft-start; released otherwise.
// RULE14: fault flag released on overload trip, pulled low normally.
// RULE15: reference enabled only with boost enable high and rail above 2.5V.
// RULE16: below 2.5V startup oscillator drives boost; above, PWM takes over.
// RULE17: cycle ends on timing trip, then 150ns discharge before next cycle.
// RULE18: aux3 gate drives a P switch, active low.
// RULE19: aux2 gate active low in inverting variant, else like aux1.
// RULE20: aux gates turn switch on at start of each oscillator cycle.
// RULE21: aux gates turn off by 80% of the period at the latest.
// RULE22: buck stays inactive until boost regulates.
// RULE23: per-channel fault timer clears whenever out-of-regulation drops.
// RULE24: soft-start counter steps reference in equal increments to full scale.
`timescale 1ns/100ps
`default_nettype none
module msseq_sequencer #(
  parameter int AUX_SS_P = msseq_pkg::AUX_SS_CYCLES,
  parameter int BUCK_SS_P = msseq_pkg::BUCK_SS_CYCLES,
  parameter int BOOST_START_P = msseq_pkg::BOOST_START_CYCLES,
  parameter int FAULT_P = msseq_pkg::FAULT_CYCLES
) (
  input wire logic clock, // 250 MHz
  input wire logic srst, // sync reset, high
  input wire msseq_pkg::msseq_apb_type apb, // apb request
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped
  input wire logic boost_enable_in, // boost enable
  input wire logic buck_enable_in, // buck enable
  input wire logic aux1_enable_in, // aux1 enable
  input wire logic aux2_enable_in, // aux2 enable
  input wire logic aux3_enable_in, // aux3 enable
  input wire msseq_pkg::msseq_sense_type sense, // comparators
  output logic boostStartupOscEn, // startup oscillator drives switch
  output logic boostPwmEn, // pwm loop drives switch
  output logic refEnable, // reference on
  output logic [msseq_pkg::NCH-1:0] chanEnable, // buck,aux1..3 run
  output logic [msseq_pkg::NCH-1:0][msseq_pkg::REF_W-1:0] refCode, // ramp
  output logic timingDischarge, // timing node discharge switch
  output logic aux1_gate, // aux1 gate level
  output logic aux2_gate, // aux2 gate level
  output logic aux3_gate, // aux3 gate level
  output logic buck_good_n_o, // open drain data
  output logic buck_good_n_oe, // high pulls low
  output logic aux1_good_n_o, // open drain data
  output logic aux1_good_n_oe, // high pulls low
  output logic fault_flag_o, // open drain data
  output logic fault_flag_oe // high pulls low
);
  localparam int DIS_I = msseq_pkg::DISCHARGE_CYC;
  localparam int DIS_M1 = msseq_pkg::DISCHARGE_CYC - 1;

  if (AUX_SS_P < 1 || AUX_SS_P > 4096 || 4096 % AUX_SS_P != 0)
  begin : g_chk_aux
    $error("aux soft-start count must divide 4096");
  end
  if (BUCK_SS_P < 1 || BUCK_SS_P > 4096 || 4096 % BUCK_SS_P != 0)
  begin : g_chk_buck
    $error("buck soft-start count must divide 4096");
  end
  if (BOOST_START_P < 1 || BOOST_START_P >= (1 << msseq_pkg::SS_W))
  begin : g_chk_start
    $error("boost start count out of range");
  end
  if (FAULT_P < 2 || FAULT_P >= (1 << msseq_pkg::FT_W))
  begin : g_chk_fault
    $error("fault count out of range");
  end

  function automatic logic [msseq_pkg::SS_W-1:0] ssLen(input int ch);
    ssLen = (ch == msseq_pkg::CH_BUCK) ? msseq_pkg::SS_W'(BUCK_SS_P)
                                       : msseq_pkg::SS_W'(AUX_SS_P);
  endfunction : ssLen

  function automatic logic [msseq_pkg::REF_W-1:0] ssRef(
    input logic [msseq_pkg::SS_W-1:0] cnt, input int ch);
    logic [msseq_pkg::REF_W+msseq_pkg::SS_W-1:0] prod;
    prod = cnt * (msseq_pkg::REF_FULL / ssLen(ch));
    ssRef = prod[msseq_pkg::REF_W-1:0];
  endfunction : ssRef

  function automatic logic [msseq_pkg::PER_W-1:0] maxOn(
    input logic [msseq_pkg::PER_W-1:0] per);
    int prod;
    prod = (int'(per) * msseq_pkg::DUTY_NUM) / msseq_pkg::DUTY_DEN;
    maxOn = prod[msseq_pkg::PER_W-1:0];
  endfunction : maxOn

  msseq_pkg::msseq_state_type s_q;
  msseq_pkg::msseq_state_type s_d;
  logic tick;
  logic uv;
  logic boostRun;
  logic faultSet;
  logic ftHit;
  logic [msseq_pkg::NCH-1:0] enIn;
  logic [msseq_pkg::NCH-1:0] chanOn;
  logic [msseq_pkg::NCH-1:0] ssDone;
  logic [msseq_pkg::NFT-1:0] ftActive;
  logic [2:0] dutyOver;
  logic access;
  logic addrOk;

  assign enIn = {aux3_enable_in, aux2_enable_in, aux1_enable_in,
                 buck_enable_in};
  assign access = apb.psel & apb.penable;
  assign addrOk = apb.paddr == msseq_pkg::ADDR_CTRL
               || apb.paddr == msseq_pkg::ADDR_STATUS
               || apb.paddr == msseq_pkg::ADDR_REF_LO
               || apb.paddr == msseq_pkg::ADDR_REF_HI;

  always_comb
  begin
    s_d = s_q;
    tick = 1'b0;
    faultSet = 1'b0;
    ftHit = 1'b0;
    uv = ~sense.boostAboveUv;
    boostRun = boost_enable_in & ~s_q.fault; // RULE1
    // oscillator: charge until trip, then fixed discharge
    case (s_q.osc)
      msseq_pkg::OSC_CHARGE:
      begin
        if (!(boost_enable_in && sense.boostAboveUv))
        begin
          s_d.oscCnt = '0;
        end
        else if (sense.timingTrip)
        begin
          s_d.osc = msseq_pkg::OSC_DISCHARGE; // RULE17
          s_d.period = s_q.oscCnt + msseq_pkg::PER_W'(DIS_I + 1);
          s_d.oscCnt = '0;
        end
        else if (s_q.oscCnt != '1)
        begin
          s_d.oscCnt = s_q.oscCnt + 1'b1;
        end
      end
      msseq_pkg::OSC_DISCHARGE:
      begin
        if (s_q.oscCnt == msseq_pkg::PER_W'(DIS_M1))
        begin
          s_d.osc = msseq_pkg::OSC_CHARGE; // RULE17
          s_d.oscCnt = '0;
          tick = 1'b1;
        end
        else
        begin
          s_d.oscCnt = s_q.oscCnt + 1'b1;
        end
      end
      default:
      begin
        s_d.osc = msseq_pkg::OSC_CHARGE;
        s_d.oscCnt = '0;
      end
    endcase
    s_d.discharge = s_d.osc == msseq_pkg::OSC_DISCHARGE;

    // boost: no ramp, start interval guards against persisting overload
    if (!boostRun || uv)
    begin
      s_d.boostUp = 1'b0; // RULE9
      s_d.startCnt = '0; // RULE10
    end
    else if (sense.boostRegOk)
    begin
      s_d.boostUp = 1'b1; // RULE4
    end
    else if (!s_q.boostUp && tick)
    begin
      s_d.startCnt = s_q.startCnt + 1'b1;
      if (s_q.startCnt == msseq_pkg::SS_W'(BOOST_START_P - 1))
      begin
        faultSet = 1'b1; // RULE11
      end
    end
    s_d.startOsc = boostRun & uv; // RULE16
    s_d.pwmEn = boostRun & ~uv; // RULE16
    s_d.refEn = boost_enable_in & ~uv; // RULE15

    // sequenced channels wait for the boost rail
    for (int i = 0; i < msseq_pkg::NCH; i++)
    begin
      chanOn[i] = enIn[i] & s_q.boostUp & boostRun & ~uv; // RULE2 RULE22
      ssDone[i] = s_q.ssCnt[i] == ssLen(i);
      if (!chanOn[i])
      begin
        s_d.ssCnt[i] = '0;
      end
      else if (tick && !ssDone[i])
      begin
        s_d.ssCnt[i] = s_q.ssCnt[i] + 1'b1; // RULE3 RULE5
      end
      s_d.refCode[i] = ssRef(s_d.ssCnt[i], i); // RULE24
      ftActive[i] = chanOn[i] & ssDone[i]; // RULE8
    end
    s_d.chanOn = chanOn;
    ftActive[msseq_pkg::FT_BOOST] = s_q.boostUp & boostRun & ~uv;

    // fault timers count unbroken out-of-regulation cycles only
    for (int i = 0; i < msseq_pkg::NFT; i++)
    begin
      if (!ftActive[i] || !sense.outOfReg[i])
      begin
        s_d.ftCnt[i] = '0; // RULE23
      end
      else if (tick)
      begin
        s_d.ftCnt[i] = s_q.ftCnt[i] + 1'b1;
        if (s_q.ftCnt[i] == msseq_pkg::FT_W'(FAULT_P - 1))
        begin
          ftHit = 1'b1; // RULE6
        end
      end
    end
    faultSet = faultSet | ftHit;
    // set wins over the enable-low clear
    if (faultSet)
    begin
      s_d.fault = 1'b1; // RULE6
    end
    else if (!boost_enable_in)
    begin
      s_d.fault = 1'b0; // RULE7
    end

    // aux gates: on at cycle start, off by comparator or duty limit
    for (int g = 0; g < 3; g++)
    begin
      // drop one cycle early: the gate register adds a cycle of on time
      dutyOver[g] = s_q.period != '0
        && s_q.oscCnt >= maxOn(s_q.period) - 1'b1;
      if (!chanOn[g + 1] || s_d.fault)
      begin
        s_d.gateOn[g] = 1'b0;
      end
      else if (tick)
      begin
        s_d.gateOn[g] = 1'b1; // RULE20
      end
      else if (sense.pulseEnd[g] || s_q.osc != msseq_pkg::OSC_CHARGE
               || dutyOver[g])
      begin
        s_d.gateOn[g] = 1'b0; // RULE21
      end
    end
    s_d.gateLvl[0] = s_d.gateOn[0];
    s_d.gateLvl[1] = s_q.invert ? ~s_d.gateOn[1] : s_d.gateOn[1]; // RULE19
    s_d.gateLvl[2] = ~s_d.gateOn[2]; // RULE18

    // status pins
    s_d.goodBuck = s_d.chanOn[msseq_pkg::CH_BUCK] & ~sense.thermalLimit
      & (s_d.ssCnt[msseq_pkg::CH_BUCK] == ssLen(msseq_pkg::CH_BUCK)); // RULE12
    s_d.goodAux1 = s_d.chanOn[msseq_pkg::CH_AUX1] & ~sense.thermalLimit
      & (s_d.ssCnt[msseq_pkg::CH_AUX1] == ssLen(msseq_pkg::CH_AUX1)); // RULE13
    s_d.flagLow = ~s_d.fault; // RULE14

    // apb: read data latched in setup, write lands in access phase
    if (access && apb.pwrite && apb.paddr == msseq_pkg::ADDR_CTRL)
    begin
      s_d.invert = apb.pwdata[msseq_pkg::CTRL_INVERT];
    end
    if (apb.psel && !apb.penable)
    begin
      s_d.prdata = '0;
      case (apb.paddr)
        msseq_pkg::ADDR_CTRL:
        begin
          s_d.prdata[msseq_pkg::CTRL_INVERT] = s_q.invert;
        end
        msseq_pkg::ADDR_STATUS:
        begin
          s_d.prdata[msseq_pkg::ST_FAULT] = s_q.fault;
          s_d.prdata[msseq_pkg::ST_UV] = uv;
          s_d.prdata[msseq_pkg::ST_BOOST_UP] = s_q.boostUp;
          s_d.prdata[msseq_pkg::ST_THERMAL] = sense.thermalLimit;
          s_d.prdata[msseq_pkg::ST_ON +: msseq_pkg::NCH] = s_q.chanOn;
          s_d.prdata[msseq_pkg::ST_DONE +: msseq_pkg::NCH] = ssDone;
        end
        msseq_pkg::ADDR_REF_LO:
        begin
          s_d.prdata[msseq_pkg::REF_W-1:0] = s_q.refCode[0];
          s_d.prdata[msseq_pkg::REF_HI_SHIFT +: msseq_pkg::REF_W] =
            s_q.refCode[1];
        end
        msseq_pkg::ADDR_REF_HI:
        begin
          s_d.prdata[msseq_pkg::REF_W-1:0] = s_q.refCode[2];
          s_d.prdata[msseq_pkg::REF_HI_SHIFT +: msseq_pkg::REF_W] =
            s_q.refCode[3];
        end
        default:
        begin
          s_d.prdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      s_q <= '0;
      s_q.osc <= msseq_pkg::OSC_CHARGE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // zero-wait slave: answer in the first access cycle
  assign pready = access;
  assign pslverr = access & ~addrOk;
  assign prdata = s_q.prdata;
  assign boostStartupOscEn = s_q.startOsc;
  assign boostPwmEn = s_q.pwmEn;
  assign refEnable = s_q.refEn;
  assign chanEnable = s_q.chanOn;
  assign refCode = s_q.refCode;
  assign timingDischarge = s_q.discharge;
  assign aux1_gate = s_q.gateLvl[0];
  assign aux2_gate = s_q.gateLvl[1];
  assign aux3_gate = s_q.gateLvl[2];
  assign buck_good_n_o = 1'b0;
  assign buck_good_n_oe = s_q.goodBuck;
  assign aux1_good_n_o = 1'b0;
  assign aux1_good_n_oe = s_q.goodAux1;
  assign fault_flag_o = 1'b0;
  assign fault_flag_oe = s_q.flagLow;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  property p_boost_alone;
    (boost_enable_in && !s_q.fault && sense.boostAboveUv)
      |=> boostPwmEn && !boostStartupOscEn;
  endproperty
  a_boost_alone: assert property (p_boost_alone) // RULE1
    else $error("boost did not start on its own enable");

  property p_wait_boost;
    (|chanEnable) |-> $past(s_q.boostUp) && $past(boost_enable_in);
  endproperty
  a_wait_boost: assert property (p_wait_boost) // RULE2
    else $error("channel ran before boost regulated");

  property p_ramp_full;
    $rose(ssDone[msseq_pkg::CH_AUX1])
      |-> refCode[msseq_pkg::CH_AUX1] == msseq_pkg::REF_FULL;
  endproperty
  a_ramp_full: assert property (p_ramp_full) // RULE3
    else $error("aux ramp did not end at full scale");

  property p_buck_full;
    $rose(ssDone[msseq_pkg::CH_BUCK])
      |-> s_q.ssCnt[msseq_pkg::CH_BUCK] == msseq_pkg::SS_W'(BUCK_SS_P)
          && refCode[msseq_pkg::CH_BUCK] == msseq_pkg::REF_FULL;
  endproperty
  a_buck_full: assert property (p_buck_full) // RULE5
    else $error("buck ramp length wrong");

  property p_fault_trip;
    ftHit |=> s_q.fault ##1 (!fault_flag_oe && chanEnable == '0);
  endproperty
  a_fault_trip: assert property (p_fault_trip) // RULE6
    else $error("fault timer expiry did not latch outputs off");

  property p_fault_hold;
    (s_q.fault && boost_enable_in) |=> s_q.fault;
  endproperty
  a_fault_hold: assert property (p_fault_hold) // RULE7
    else $error("fault latch cleared while boost enabled");

  property p_no_fault_in_ramp;
    !ssDone[msseq_pkg::CH_BUCK] |-> s_q.ftCnt[msseq_pkg::CH_BUCK] == '0;
  endproperty
  a_no_fault_in_ramp: assert property (p_no_fault_in_ramp) // RULE8
    else $error("fault timer ran during soft-start");

  property p_uv_shutdown;
    !sense.boostAboveUv |=> chanEnable == '0 && !boostPwmEn && !refEnable;
  endproperty
  a_uv_shutdown: assert property (p_uv_shutdown) // RULE9
    else $error("undervoltage did not shut channels at once");

  sequence s_discharge_run;
    timingDischarge [*1] ##DIS_M1 timingDischarge ##1 !timingDischarge;
  endsequence
  property p_discharge;
    $rose(timingDischarge) |-> s_discharge_run;
  endproperty
  a_discharge: assert property (p_discharge) // RULE17
    else $error("discharge interval wrong");

  sequence s_duty_over;
    s_q.gateOn[0] && dutyOver[0] && s_q.osc == msseq_pkg::OSC_CHARGE
      && !tick;
  endsequence
  property p_duty_limit;
    s_duty_over |=> !s_q.gateOn[0] ##0 !aux1_gate;
  endproperty
  a_duty_limit: assert property (p_duty_limit) // RULE21
    else $error("aux gate past maximum duty");

  property p_aux3_low;
    (tick && chanOn[msseq_pkg::CH_AUX3] && !s_d.fault) |=> !aux3_gate;
  endproperty
  a_aux3_low: assert property (p_aux3_low) // RULE18
    else $error("aux3 gate not low at cycle start");
endmodule : msseq_sequencer
`default_nettype wire

// ==== verif/msseq_partner.sv ====
`timescale 1ns/100ps
`default_nettype none
module msseq_partner (
  input wire logic clock, // system clock
  input wire logic srst, // sync reset
  input wire logic timingDischarge, // discharge switch closed
  input wire logic railUp, // rail above undervoltage
  input wire logic regOk, // boost loop in regulation
  input wire logic [4:0] outOfReg, // per channel error level
  input wire logic thermal, // thermal limit comparator
  output var msseq_pkg::msseq_sense_type sense // comparator levels
);
  // long charge so the 80% duty limit, not the discharge, ends the pulse
  logic [7:0] chargeQ;

  // timing node ramps only while the switch is open
  always_ff @(posedge clock)
  begin
    if (srst || timingDischarge)
      chargeQ <= 8'h00;
    else if (chargeQ != 8'hFF)
      chargeQ <= chargeQ + 8'h01;
  end

  always_comb
  begin
    sense = '0;
    sense.boostAboveUv = railUp;
    // a collapsed rail cannot regulate
    sense.boostRegOk = regOk && railUp;
    sense.outOfReg = outOfReg;
    sense.thermalLimit = thermal;
    // stays tripped until the one-shot discharges
    sense.timingTrip = chargeQ >= 8'hA0;
  end
endmodule : msseq_partner
`default_nettype wire

// ==== verif/msseq_sequencer_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module msseq_sequencer_bench;
  logic clock = 1'b0;
  logic srst = 1'b1;
  msseq_pkg::msseq_apb_type apbBus = '0;
  logic [4:0] en = '0;
  logic railUp = 1'b0;
  logic regOk = 1'b0;
  logic [4:0] oor = '0;
  logic thermal = 1'b0;
  msseq_pkg::msseq_sense_type sense;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err;
  logic startOsc, pwmEn, refEn, disch, g1, g2, g3, bOe, a1Oe, fOe;
  logic [3:0] chanEnable;
  logic [3:0][msseq_pkg::REF_W-1:0] refCode;
  int errors = 0;
  int numChecks = 0;

  msseq_sequencer #(
    .AUX_SS_P(16),
    .BUCK_SS_P(8),
    .BOOST_START_P(16),
    .FAULT_P(20)
  ) i_msseq_sequencer (
    .clock, .srst, .apb(apbBus), .prdata, .pready, .pslverr,
    .boost_enable_in(en[0]), .buck_enable_in(en[1]),
    .aux1_enable_in(en[2]), .aux2_enable_in(en[3]),
    .aux3_enable_in(en[4]), .sense, .boostStartupOscEn(startOsc),
    .boostPwmEn(pwmEn), .refEnable(refEn), .chanEnable, .refCode,
    .timingDischarge(disch), .aux1_gate(g1), .aux2_gate(g2),
    .aux3_gate(g3), .buck_good_n_o(), .buck_good_n_oe(bOe),
    .aux1_good_n_o(), .aux1_good_n_oe(a1Oe), .fault_flag_o(),
    .fault_flag_oe(fOe)
  );

  msseq_partner i_msseq_partner (
    .clock, .srst, .timingDischarge(disch), .railUp, .regOk,
    .outOfReg(oor), .thermal, .sense
  );

  initial
    forever #2 clock = ~clock;

  task automatic summarize();
    $display("checks %0d errors %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    numChecks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s: expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic expire(input int i, input int lim);
    if (i >= lim)
    begin
      errors++;
      $display("wrong value wait: expected done seen timeout");
      summarize();
    end
  endtask : expire

  function automatic logic sig(input int which);
    case (which)
      0: sig = bOe;
      1: sig = a1Oe;
      default: sig = fOe;
    endcase
  endfunction : sig

  task automatic waitSig(input int which, input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim && sig(which) !== lvl; i++)
      @(negedge clock);
    expire(i, lim);
  endtask : waitSig

  // request held until pready is sampled high
  task automatic apbXfer(input logic wr, input logic [7:0] a,
    input logic [31:0] wd);
    int i;
    @(posedge clock);
    apbBus <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clock);
    apbBus.penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clock);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    apbBus <= '0;
    expire(i, 20);
  endtask : apbXfer

  task automatic tStart();
    repeat (3) @(negedge clock);
    check("flag", 1, fOe);
    check("ref", 0, refEn);
    @(posedge clock);
    en <= 5'h1F;
    repeat (4) @(negedge clock);
    check("osc", 1, startOsc);
    check("pwm", 0, pwmEn);
    check("ref", 0, refEn);
    @(posedge clock);
    railUp <= 1'b1;
    repeat (4) @(negedge clock);
    check("pwm", 1, pwmEn);
    check("osc", 0, startOsc);
    check("ref", 1, refEn);
    repeat (100) @(negedge clock);
    check("chan", 0, chanEnable);
    $display("start test done");
  endtask : tStart

  task automatic tRamp();
    @(posedge clock);
    regOk <= 1'b1;
    oor <= 5'h0F;
    waitSig(0, 1'b1, 5000);
    check("buck ref", msseq_pkg::REF_FULL, refCode[0]);
    check("aux1 ref", msseq_pkg::REF_FULL >> 1, refCode[1]);
    check("aux1 good", 0, a1Oe);
    waitSig(1, 1'b1, 5000);
    check("aux1 ref", msseq_pkg::REF_FULL, refCode[1]);
    check("chan", 4'hF, chanEnable);
    check("flag", 1, fOe);
    @(posedge clock);
    oor <= '0;
    $display("ramp test done");
  endtask : tRamp

  // whole periods only, counted from one switch-on to the next
  task automatic tGates(input logic inv);
    int i, n, t, hi;
    logic prev;
    n = 0;
    t = 0;
    hi = 0;
    prev = 1'b1;
    repeat (2) @(negedge clock);
    for (i = 0; i < 3000 && n < 9; i++)
    begin
      @(negedge clock);
      n += (g1 && !prev) ? 1 : 0;
      prev = g1;
      if (n > 0 && n < 9)
      begin
        t++;
        hi += g1 ? 1 : 0;
      end
      check("aux3", !g1, g3);
      check("aux2", inv ? !g1 : g1, g2);
    end
    expire(i, 3000);
    check("duty", 1, hi > 0 && hi * 5 <= t * 4);
    $display("gate test done");
  endtask : tGates

  task automatic tRegs();
    apbXfer(1'b0, msseq_pkg::ADDR_STATUS, 32'h0);
    check("status", 12'hFF4, rd[11:0]);
    apbXfer(1'b1, msseq_pkg::ADDR_REF_LO, 32'h0);
    apbXfer(1'b0, msseq_pkg::ADDR_REF_LO, 32'h0);
    check("ref lo", 32'h10001000, rd);
    apbXfer(1'b0, 8'h10, 32'h0);
    check("unmapped err", 1, err);
    check("unmapped data", 0, rd);
    apbXfer(1'b0, msseq_pkg::ADDR_CTRL, 32'h0);
    check("ctrl", 1, rd[0]);
    @(posedge clock);
    thermal <= 1'b1;
    repeat (2) @(negedge clock);
    check("buck good", 0, bOe);
    check("aux1 good", 0, a1Oe);
    @(posedge clock);
    thermal <= 1'b0;
    repeat (2) @(negedge clock);
    check("buck good", 1, bOe);
    check("aux1 good", 1, a1Oe);
    $display("register test done");
  endtask : tRegs

  task automatic tFault();
    int i;
    for (i = 0; i < 3; i++)
    begin
      @(posedge clock);
      oor[msseq_pkg::CH_AUX3] <= 1'b1;
      repeat (1600) @(posedge clock);
      oor[msseq_pkg::CH_AUX3] <= 1'b0;
      repeat (60) @(posedge clock);
    end
    check("flag", 1, fOe);
    oor[msseq_pkg::CH_AUX3] <= 1'b1;
    repeat (3000) @(negedge clock);
    check("flag", 1, fOe);
    waitSig(2, 1'b0, 2000);
    repeat (2) @(negedge clock);
    check("chan", 0, chanEnable);
    check("aux3 off", 1, g3);
    check("buck good", 0, bOe);
    check("aux1 good", 0, a1Oe);
    @(posedge clock);
    oor <= '0;
    repeat (100) @(negedge clock);
    check("flag", 0, fOe);
    @(posedge clock);
    en[0] <= 1'b0;
    @(posedge clock);
    en[0] <= 1'b1;
    waitSig(2, 1'b1, 20);
    $display("fault test done");
  endtask : tFault

  task automatic tUv();
    @(posedge clock);
    railUp <= 1'b0;
    repeat (3) @(negedge clock);
    check("chan", 0, chanEnable);
    check("ref", 0, refEn);
    check("osc", 1, startOsc);
    @(posedge clock);
    railUp <= 1'b1;
    repeat (3) @(negedge clock);
    check("pwm", 1, pwmEn);
    check("flag", 1, fOe);
    $display("undervoltage test done");
  endtask : tUv

  task automatic tOverload();
    @(posedge clock);
    regOk <= 1'b0;
    en[0] <= 1'b0;
    @(posedge clock);
    en[0] <= 1'b1;
    repeat (2600) @(negedge clock);
    check("flag", 1, fOe);
    waitSig(2, 1'b0, 2000);
    $display("overload test done");
  endtask : tOverload

  initial
  begin
    #400000;
    errors++;
    summarize();
  end

  initial
  begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    tStart();
    tRamp();
    tGates(1'b0);
    apbXfer(1'b1, msseq_pkg::ADDR_CTRL, 32'h1);
    tGates(1'b1);
    tRegs();
    tFault();
    tUv();
    tOverload();
    summarize();
  end
endmodule : msseq_sequencer_bench
`default_nettype wire
